//--- hw/dual_dac_ctrl.sv
// Serial control logic of a dual 12-bit converter: shift path, decode and output state
`timescale 1ns/1ns
module dual_dac_ctrl
    import dac_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic shutdown_lockout_n_i,
    output logic dout_o,
    output logic user_logic_output_o,
    output logic [DATA_W-1:0] dac_a_code_o,
    output logic [DATA_W-1:0] dac_b_code_o,
    output logic pd_a_o,
    output logic pd_b_o,
    output logic out_mode_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_pipe_ff;
    logic [1:0] nxt_rst_pipe;
    logic rst_n;

    always_comb begin
        nxt_rst_pipe = {rst_pipe_ff[0], 1'b1};
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_pipe_ff <= RST_PIPE_RST;
        end else begin
            rst_pipe_ff <= nxt_rst_pipe;
        end
    end

    assign rst_n = rst_pipe_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain: shift register and serial output

    logic [WORD_W-1:0] shift_ff;
    logic [WORD_W-1:0] nxt_shift;
    logic dout_fall_ff;
    logic nxt_dout_fall;
    logic mode_link;
    logic mode_ff;

    // Chip select and data are timed by the host against the shift clock edge,
    // so they qualify the shifter directly; a synchroniser would cost two edges.
    always_comb begin
        if (!cs_n_i) begin
            nxt_shift = {shift_ff[WORD_W-2:0], din_i};
        end else begin
            nxt_shift = shift_ff;
        end
    end

    always_ff @(posedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_ff <= WORD_RST;
        end else begin
            shift_ff <= nxt_shift;
        end
    end

    // Half a cycle after the shift, giving the full 16-cycle lag
    always_comb begin
        nxt_dout_fall = shift_ff[WORD_W-1];
    end

    always_ff @(negedge sclk_i or negedge rst_n) begin
        if (!rst_n) begin
            dout_fall_ff <= 1'b0;
        end else begin
            dout_fall_ff <= nxt_dout_fall;
        end
    end

    // Mode only changes between frames, so two link edges of delay are harmless
    bit_sync #(
        .RST_VAL(1'b0)
    ) u_mode_sync (
        .clk_i(sclk_i),
        .rst_n_i(rst_n),
        .d_i(mode_ff),
        .q_o(mode_link)
    );

    // Dual-edge output cannot come from one flop; the mux picks the edge domain.
    // Rising mode shows the last stage as it shifts, a lag of 15.5 cycles.
    assign dout_o = (mode_link == OUT_RISE) ? shift_ff[WORD_W-1] : dout_fall_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers in the system domain

    logic cs_n_sync;
    logic lock_n_sync;
    logic cs_prev_ff;
    logic lock_prev_ff;
    logic nxt_cs_prev;
    logic nxt_lock_prev;
    logic cs_rise;
    logic lock_fall;

    bit_sync #(
        .RST_VAL(1'b1)
    ) u_cs_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(cs_n_i),
        .q_o(cs_n_sync)
    );

    // Runs on the free system clock, so the wake needs no link activity
    bit_sync #(
        .RST_VAL(1'b1)
    ) u_lock_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(shutdown_lockout_n_i),
        .q_o(lock_n_sync)
    );

    always_comb begin
        nxt_cs_prev = cs_n_sync;
        nxt_lock_prev = lock_n_sync;
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_prev_ff <= 1'b1;
            lock_prev_ff <= 1'b1;
        end else begin
            cs_prev_ff <= nxt_cs_prev;
            lock_prev_ff <= nxt_lock_prev;
        end
    end

    assign cs_rise = cs_n_sync & ~cs_prev_ff;
    assign lock_fall = lock_prev_ff & ~lock_n_sync;

    ////////////////////////////////////////////////////////////////////////////////
    // Word capture and decode

    // The shifter is frozen while chip select is high, so its word is read
    // quasi-statically after the synchronised rising edge. Limitation: the host
    // must not lower chip select again within a few system clocks of raising it.
    logic [WORD_W-1:0] word;
    logic addr;
    ctl_t ctl;
    subop_t subop;
    logic [DATA_W-1:0] data;

    assign word = shift_ff;
    assign addr = word[ADDR_BIT];
    assign ctl = ctl_t'(word[CTL_HI:CTL_LO]);
    assign subop = subop_t'(word[SUBOP_HI:SUBOP_LO]);
    assign data = word[DATA_HI:DATA_LO];

    logic [DATA_W-1:0] in_a_ff;
    logic [DATA_W-1:0] in_b_ff;
    logic [DATA_W-1:0] dac_a_ff;
    logic [DATA_W-1:0] dac_b_ff;
    logic pd_a_ff;
    logic pd_b_ff;
    logic upo_ff;
    logic [DATA_W-1:0] nxt_in_a;
    logic [DATA_W-1:0] nxt_in_b;
    logic [DATA_W-1:0] nxt_dac_a;
    logic [DATA_W-1:0] nxt_dac_b;
    logic nxt_pd_a;
    logic nxt_pd_b;
    logic nxt_upo;
    logic nxt_mode;

    always_comb begin
        nxt_in_a = in_a_ff;
        nxt_in_b = in_b_ff;
        nxt_dac_a = dac_a_ff;
        nxt_dac_b = dac_b_ff;
        nxt_pd_a = pd_a_ff;
        nxt_pd_b = pd_b_ff;
        nxt_upo = upo_ff;
        nxt_mode = mode_ff;
        // Input registers are untouched here, so they survive power-down
        if (lock_fall) begin
            nxt_pd_a = 1'b0;
            nxt_pd_b = 1'b0;
        end
        if (cs_rise) begin
            unique case (ctl)
                CTL_LOAD_IN: begin
                    if (addr) begin
                        nxt_in_b = data;
                    end else begin
                        nxt_in_a = data;
                    end
                end
                CTL_LOAD_BOTH: begin
                    if (addr) begin
                        nxt_in_b = data;
                        nxt_dac_b = data;
                        nxt_pd_b = 1'b0;
                    end else begin
                        nxt_in_a = data;
                        nxt_dac_a = data;
                        nxt_pd_a = 1'b0;
                    end
                end
                CTL_LOAD_UPD: begin
                    if (addr) begin
                        nxt_in_b = data;
                        nxt_dac_b = data;
                        nxt_dac_a = in_a_ff;
                    end else begin
                        nxt_in_a = data;
                        nxt_dac_a = data;
                        nxt_dac_b = in_b_ff;
                    end
                    nxt_pd_a = 1'b0;
                    nxt_pd_b = 1'b0;
                end
                CTL_SPECIAL: begin
                    unique case (subop)
                        SUB_NOP: begin
                            nxt_mode = mode_ff;
                        end
                        SUB_UPDATE_ALL: begin
                            nxt_dac_a = in_a_ff;
                            nxt_dac_b = in_b_ff;
                            nxt_pd_a = 1'b0;
                            nxt_pd_b = 1'b0;
                        end
                        SUB_SHDN_ONE: begin
                            if (lock_n_sync) begin
                                if (addr) begin
                                    nxt_pd_b = 1'b1;
                                end else begin
                                    nxt_pd_a = 1'b1;
                                end
                            end
                        end
                        SUB_SHDN_ALL: begin
                            if (lock_n_sync) begin
                                nxt_pd_a = 1'b1;
                                nxt_pd_b = 1'b1;
                            end
                        end
                        SUB_MODE_FALL: begin
                            nxt_mode = OUT_FALL;
                        end
                        SUB_MODE_RISE: begin
                            nxt_mode = OUT_RISE;
                        end
                        SUB_UPO_LOW: begin
                            nxt_upo = 1'b0;
                        end
                        SUB_UPO_HIGH: begin
                            nxt_upo = 1'b1;
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_a_ff <= CODE_RST;
            in_b_ff <= CODE_RST;
            dac_a_ff <= CODE_RST;
            dac_b_ff <= CODE_RST;
            pd_a_ff <= 1'b0;
            pd_b_ff <= 1'b0;
            upo_ff <= 1'b0;
            mode_ff <= OUT_FALL;
        end else begin
            in_a_ff <= nxt_in_a;
            in_b_ff <= nxt_in_b;
            dac_a_ff <= nxt_dac_a;
            dac_b_ff <= nxt_dac_b;
            pd_a_ff <= nxt_pd_a;
            pd_b_ff <= nxt_pd_b;
            upo_ff <= nxt_upo;
            mode_ff <= nxt_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign user_logic_output_o = upo_ff;
    assign dac_a_code_o = dac_a_ff;
    assign dac_b_code_o = dac_b_ff;
    assign pd_a_o = pd_a_ff;
    assign pd_b_o = pd_b_ff;
    assign out_mode_o = mode_ff;

endmodule : dual_dac_ctrl

//--- hw/dac_ctrl_pkg.sv
// Constants, field layout and command encodings for the dual converter control block
// Operation
// - Serial data out comes from the shift register's last stage, directly in rising mode, via a falling-edge flop in falling mode.
// - Falling-edge mode updates serial out on falling shift clock, 16-cycle lag.
// - Rising-edge mode updates serial out on rising shift clock, 15.5-cycle lag.
// - After power-up the falling-edge output mode is selected.
// - A serial command sets the user logic output level.
// - User logic output is low after power-up until a command changes it.
// - While lockout is low, shutdown commands are ignored.
// - Lockout falling during power-down wakes both channels with held values.
// - Lockout wake needs no shift clock or chip select activity.
// - Power-up clears both channels' input and converter registers to zero.
// - Words are 16 bits, MSB first: address, two control, twelve data, sub-bit.
// - With chip select low, data is sampled on each rising shift clock.
// - Chip select rising transfers the word into registers chosen by its command.
// - In power-down the serial interface runs and input registers are kept.
package dac_ctrl_pkg;

    localparam int WORD_W = 16;
    localparam int DATA_W = 12;

    // Serial word layout, bit 15 arrives first
    localparam int ADDR_BIT = 15;
    localparam int CTL_HI = 14;
    localparam int CTL_LO = 13;
    localparam int DATA_HI = 12;
    localparam int DATA_LO = 1;
    localparam int SUB_BIT = 0;

    // Sub-operation field of a special command sits in the top data bits
    localparam int SUBOP_HI = 12;
    localparam int SUBOP_LO = 10;

    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_RST = 12'h000;
    localparam logic [1:0] RST_PIPE_RST = 2'h0;

    typedef enum logic [1:0] {
        CTL_SPECIAL = 2'b00,
        CTL_LOAD_IN = 2'b01,
        CTL_LOAD_BOTH = 2'b10,
        CTL_LOAD_UPD = 2'b11
    } ctl_t;

    typedef enum logic [2:0] {
        SUB_NOP = 3'b000,
        SUB_UPDATE_ALL = 3'b001,
        SUB_SHDN_ONE = 3'b010,
        SUB_SHDN_ALL = 3'b011,
        SUB_MODE_FALL = 3'b100,
        SUB_MODE_RISE = 3'b101,
        SUB_UPO_LOW = 3'b110,
        SUB_UPO_HIGH = 3'b111
    } subop_t;

    typedef enum logic {
        OUT_FALL = 1'b0,
        OUT_RISE = 1'b1
    } out_mode_t;

endpackage : dac_ctrl_pkg

//--- hw/bit_sync.sv
// Two-stage synchroniser with a constant reset level
`timescale 1ns/1ns
module bit_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);

    logic meta_ff;
    logic q_ff;
    logic nxt_meta;
    logic nxt_q;

    // First stage is read only by the second stage
    always_comb begin
        nxt_meta = d_i;
        nxt_q = meta_ff;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= RST_VAL;
            q_ff <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;

endmodule : bit_sync

//--- tb/dual_dac_ctrl_properties.sv
// Concurrent checks on the converter control ports
`timescale 1ns/1ns
module dual_dac_ctrl_properties
    import dac_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic din_i,
    input wire logic shutdown_lockout_n_i,
    input wire logic dout_o,
    input wire logic user_logic_output_o,
    input wire logic [DATA_W-1:0] dac_a_code_o,
    input wire logic [DATA_W-1:0] dac_b_code_o,
    input wire logic pd_a_o,
    input wire logic pd_b_o,
    input wire logic out_mode_o
);
////////////////////////////////////////
logic [15:0] sh_ff, nxt_sh;
logic [1:0] bc_ff, nxt_bc;
logic [3:0] cs_cnt_ff, nxt_cs_cnt;
logic [2:0] lk_cnt_ff, nxt_lk_cnt;
// Shadow shifter; first bits of a frame skipped, mode takes two rises to land
always_comb nxt_sh = cs_n_i ? sh_ff : {sh_ff[14:0], din_i};
always_comb nxt_bc = (bc_ff == 2'h3) ? bc_ff : bc_ff + 2'h1;
always_comb nxt_cs_cnt = !cs_n_i ? 4'h0 : (cs_cnt_ff == 4'hF) ? cs_cnt_ff : cs_cnt_ff + 4'h1;
always_comb nxt_lk_cnt = shutdown_lockout_n_i ? 3'h0 : (lk_cnt_ff == 3'h7) ? 3'h7 : lk_cnt_ff + 3'h1;
always_ff @(posedge sclk_i or negedge nrst_i) if (!nrst_i) sh_ff <= 16'h0000; else sh_ff <= nxt_sh;
always_ff @(posedge sclk_i or posedge cs_n_i) if (cs_n_i) bc_ff <= 2'h0; else bc_ff <= nxt_bc;
always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
        cs_cnt_ff <= 4'h0;
        lk_cnt_ff <= 3'h0;
    end else begin
        cs_cnt_ff <= nxt_cs_cnt;
        lk_cnt_ff <= nxt_lk_cnt;
    end
end
////////////////////////////////////////
AST_DOUT_FALL: assert property (@(posedge sclk_i) disable iff (!nrst_i)
    !out_mode_o && !cs_n_i && bc_ff == 2'h3 |-> dout_o == sh_ff[15]) else $error("dout lag wrong");
AST_DOUT_RISE: assert property (@(negedge sclk_i) disable iff (!nrst_i)
    out_mode_o && !cs_n_i && bc_ff == 2'h3 |-> dout_o == sh_ff[15]) else $error("dout lag wrong");
AST_MODE_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> out_mode_o == OUT_FALL) else $error("mode not falling after reset");
AST_UPO_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |=> !user_logic_output_o) else $error("user output high after reset");
AST_CODE_RST: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> dac_a_code_o == CODE_RST && dac_b_code_o == CODE_RST) else $error("codes");
AST_CODE_CMD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(dac_a_code_o) || $changed(dac_b_code_o) |-> cs_cnt_ff inside {[2:6]})
    else $error("code changed outside a frame end");
AST_UPO_CMD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $changed(user_logic_output_o) |-> cs_cnt_ff inside {[2:6]}) else $error("user output moved");
AST_LOCK: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lk_cnt_ff == 3'h7 |-> !$rose(pd_a_o) && !$rose(pd_b_o)) else $error("shutdown under lockout");
AST_WAKE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(shutdown_lockout_n_i) && (pd_a_o || pd_b_o) |-> ##[1:6] !pd_a_o && !pd_b_o)
    else $error("no wake on lockout fall");
cover property (@(posedge clk_i) $rose(out_mode_o));
cover property (@(posedge clk_i) $rose(user_logic_output_o));
cover property (@(posedge clk_i) !shutdown_lockout_n_i && $fell(pd_b_o));
endmodule : dual_dac_ctrl_properties

bind dual_dac_ctrl dual_dac_ctrl_properties chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .shutdown_lockout_n_i(shutdown_lockout_n_i),
    .dout_o(dout_o), .user_logic_output_o(user_logic_output_o), .dac_a_code_o(dac_a_code_o),
    .dac_b_code_o(dac_b_code_o), .pd_a_o(pd_a_o), .pd_b_o(pd_b_o), .out_mode_o(out_mode_o));

//--- tb/host_model.sv
// Serial host that frames words on the link and captures serial out
`timescale 1ns/1ns
module host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o,
    input wire logic dout_i
);
logic [31:0] rr;
logic [31:0] rf;
initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    rr = 32'h0;
    rf = 32'h0;
end
// Clock stands low outside frames, so no stray edge reaches the shifter
task automatic frame(input logic [31:0] w, input int n);
    #1 cs_n_o = 1'b0;
    #20;
    for (int i = n - 1; i >= 0; i--) begin
        din_o = w[i];
        #4 rr = {rr[30:0], dout_i};
        sclk_o = 1'b1;
        #7 rf = {rf[30:0], dout_i};
        sclk_o = 1'b0;
        #4;
    end
    din_o = ~din_o;
    cs_n_o = 1'b1;
endtask : frame
endmodule : host_model

//--- tb/dual_dac_ctrl_bench.sv
// Self-checking bench for the dual converter control block
`timescale 1ns/1ns
module dual_dac_ctrl_bench
    import dac_ctrl_pkg::*;
;
logic clk_i = 1'b0, nrst_i = 1'b0, lk_n = 1'b1;
logic sclk, cs_n, din, dout, user_logic_output, pd_a, pd_b, mode;
logic [DATA_W-1:0] code_a, code_b;
logic [DATA_W-1:0] in_m [2], dac_m [2];
logic [1:0] pd_m = 2'h0;
logic upo_m = 1'b0, mode_m = 1'b0;
int error_cnt = 0, checks = 0, cyc = 0, seed;
always #5 clk_i = ~clk_i;
dual_dac_ctrl DUT (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .shutdown_lockout_n_i(lk_n), .dout_o(dout), .user_logic_output_o(user_logic_output), .dac_a_code_o(code_a),
    .dac_b_code_o(code_b), .pd_a_o(pd_a), .pd_b_o(pd_b), .out_mode_o(mode));
host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
////////////////////////////////////////
task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
        error_cnt++;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
endtask : chk
task check_all;
    // Look a little after the edge so registered outputs have settled
    #1;
    chk("code_a", 16'(code_a), 16'(dac_m[0]));
    chk("code_b", 16'(code_b), 16'(dac_m[1]));
    chk("pd", {14'h0, pd_b, pd_a}, {14'h0, pd_m});
    chk("upo", 16'(user_logic_output), 16'(upo_m));
    chk("mode", 16'(mode), 16'(mode_m));
endtask : check_all
// Reference decode of one word; lockout low blocks shutdown only
task apply(input logic [15:0] w, input logic lk);
    logic a;
    a = w[15];
    case (w[14:13])
        2'b01: in_m[a] = w[12:1];
        2'b10: begin in_m[a] = w[12:1]; dac_m[a] = w[12:1]; pd_m[a] = 1'b0; end
        2'b11: begin in_m[a] = w[12:1]; dac_m[a] = w[12:1]; dac_m[!a] = in_m[!a]; pd_m = 2'h0; end
        default: case (w[12:10])
            3'd1: begin dac_m = in_m; pd_m = 2'h0; end
            3'd2: if (lk) pd_m[a] = 1'b1;
            3'd3: if (lk) pd_m = 2'h3;
            3'd4: mode_m = 1'b0;
            3'd5: mode_m = 1'b1;
            3'd6: upo_m = 1'b0;
            3'd7: upo_m = 1'b1;
            default: ;
        endcase
    endcase
endtask : apply
task automatic step(input logic lk, input logic [15:0] w);
    logic [15:0] rb;
    rb = 16'($random(seed));
    @(posedge clk_i);
    #1;
    if (lk_n && !lk) pd_m = 2'h0;
    lk_n = lk;
    repeat (8) @(posedge clk_i);
    #1;
    chk("wake", {14'h0, pd_b, pd_a}, {14'h0, pd_m});
    host.frame({rb, w}, 32);
    if (mode_m) chk("readback", host.rf[16:1], rb);
    else chk("readback", host.rr[15:0], rb);
    apply(w, lk);
    repeat (8) @(posedge clk_i);
    check_all;
endtask : step
task report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask : report_and_stop
////////////////////////////////////////
always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
        error_cnt++;
        report_and_stop;
    end
end
initial begin
    seed = 32'hFE315B46;
    in_m = '{12'h000, 12'h000};
    dac_m = '{12'h000, 12'h000};
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    check_all;
    for (int op = 0; op < 8; op++) step(1'b1, {3'b000, 3'(op), 10'h000});
    step(1'b1, {3'b001, 12'hABC, 1'b0});
    step(1'b0, 16'h0000);
    step(1'b0, 16'h0C00);
    step(1'b0, 16'h8800);
    for (int i = 0; i < 40; i++) step(($random(seed) & 3) != 0, 16'($random(seed)));
    step(1'b1, 16'h1C00);
    step(1'b1, 16'h1400);
    step(1'b1, {3'b010, 12'h5A5, 1'b0});
    // Mid-run reset with non-default state must bring back every power-up value
    @(posedge clk_i);
    #1 nrst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    in_m = '{12'h000, 12'h000};
    dac_m = in_m;
    pd_m = 2'h0;
    upo_m = 1'b0;
    mode_m = 1'b0;
    repeat (6) @(posedge clk_i);
    check_all;
    step(1'b1, {3'b110, 12'h3C3, 1'b0});
    report_and_stop;
end
endmodule : dual_dac_ctrl_bench
